// file: ctmfl_pkg.sv
// Constants and types shared by the transceiver mode and fault logic.
// Assumes a 100 MHz clock.
// Notes on behaviour
// - Standby low: normal mode, driver and receiver on.
// - Standby high: transmitter off, low-power receiver watches.
// - Standby receive output is filtered, delayed bus copy.
// - Standby receive low on wake-up, else high.
// - Wake-up needs both supplies valid.
// - Normal mode: transmit low drives dominant, high releases.
// - Any dominant node makes the resolved bus dominant.
// - Normal receive output follows resolved bus state.
// - Over-temperature disables drivers, rest keeps running.
// - Transmit stuck low times out, drivers off until high.
// - Standby bus stuck dominant latches receive high.
// - Both dominant timeouts are nominally 1.25 ms.
// - Drivers stay off until both supplies pass.
// - Main supply undervoltage puts drivers off.
// - Normal mode main undervoltage forces receive high.
// - Low-power receiver enabled once supplies good, then latched.
// - Reference output active only in powered normal mode.
// - Undriven transmit input reads recessive.
// - Undriven standby select input selects standby.
package ctmfl_pkg;
    localparam int unsigned CLK_FREQ_MHZ = 100;
    localparam real DOM_TIMEOUT_MS = 1.25;
    localparam int unsigned DOM_TIMEOUT_CYC = int'(DOM_TIMEOUT_MS * 1000.0 * real'(CLK_FREQ_MHZ));
    localparam int unsigned TMO_W = 17;
    localparam int unsigned FIFO_WIDTH = 1;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam logic RX_RST = 1'h1;
    localparam logic DRV_RST = 1'h0;
    localparam logic FLAG_RST = 1'h0;
    typedef enum logic {MODE_NORMAL, MODE_STANDBY} ctmfl_mode_t;
endpackage : ctmfl_pkg

// file: ctmfl_fifo_if.sv
// Carrier between the wake-up filter logic and its sample FIFO.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface ctmfl_fifo_if #(parameter int unsigned W = 1);
    logic push_valid;
    logic push_ready;
    logic [W-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [W-1:0] pop_data;
    logic full;
    logic flush;
    modport user (output push_valid, push_data, pop_ready, flush,
                  input push_ready, pop_valid, pop_data, full);
    modport buffer (input push_valid, push_data, pop_ready, flush,
                    output push_ready, pop_valid, pop_data, full);
endinterface : ctmfl_fifo_if

// file: ctmfl_fifo.sv
// Synchronous flip-flop FIFO used as the wake-up filter delay line.
// Assumes one clock, an active-high asynchronous reset and a clock enable.
`timescale 1ns/100ps
module ctmfl_fifo #(
    parameter int unsigned WIDTH = 1,
    parameter int unsigned DEPTH = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // Data path
    ctmfl_fifo_if.buffer fifo
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    logic do_push;
    logic do_pop;

    assign fifo.full = (cnt_reg == (AW+1)'(DEPTH));
    assign fifo.push_ready = !fifo.full;
    assign fifo.pop_valid = (cnt_reg != '0);
    assign fifo.pop_data = mem_reg[rd_reg];
    assign do_push = fifo.push_valid && fifo.push_ready;
    assign do_pop = fifo.pop_valid && fifo.pop_ready;

    generate
        for (genvar i = 0; i < DEPTH; i++) begin : g_mem
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    mem_reg[i] <= '0;
                end else if (ce && do_push && wr_reg == AW'(i)) begin
                    mem_reg[i] <= fifo.push_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else if (ce) begin
            if (fifo.flush) begin
                wr_reg <= '0;
                rd_reg <= '0;
                cnt_reg <= '0;
            end else begin
                if (do_push) begin
                    wr_reg <= AW'(wr_reg + 1'h1);
                end
                if (do_pop) begin
                    rd_reg <= AW'(rd_reg + 1'h1);
                end
                if (do_push && !do_pop) begin
                    cnt_reg <= (AW+1)'(cnt_reg + 1'h1);
                end else if (do_pop && !do_push) begin
                    cnt_reg <= (AW+1)'(cnt_reg - 1'h1);
                end
            end
        end
    end
endmodule : ctmfl_fifo

// file: ctmfl_top.sv
// Mode control, wake-up filter and fault gating of a CAN transceiver.
// Assumes pin inputs are synchronous to clock; bus_dom_in is the wired
// bus level seen by the receiver, high when some node drives dominant.
`timescale 1ns/100ps
module ctmfl_top #(
    parameter int unsigned DOM_TIMEOUT_CYC = ctmfl_pkg::DOM_TIMEOUT_CYC
) (
    // Clock, reset and enable
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // Controller side pins
    input wire logic tx_bit_in,
    input wire logic tx_bit_driven,
    input wire logic standby_select_in,
    input wire logic standby_select_driven,
    output logic rx_bit,
    // Bus side
    input wire logic bus_dom_in,
    output logic bus_drive_dom,
    output logic bus_drive_en,
    output logic split_en,
    // Supply and thermal status
    input wire logic vdd_ok,
    input wire logic vio_ok,
    input wire logic over_temp,
    // Status
    output logic standby_active,
    output logic tx_timeout,
    output logic bus_timeout,
    output logic wake_pending
);
    import ctmfl_pkg::*;

    localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(DOM_TIMEOUT_CYC - 1);

    ctmfl_mode_t mode_reg;
    logic tx_eff;
    logic standby_eff;
    logic resolved_dom;
    logic supplies_ok;
    logic drv_ok;
    logic powered_reg;
    logic lp_en_reg;
    logic [TMO_W-1:0] tx_cnt_reg;
    logic tx_lock_reg;
    logic [TMO_W-1:0] bus_cnt_reg;
    logic bus_lock_reg;
    logic filt_dom_reg;
    logic filt_active;
    logic wake_now;
    logic rx_bit_reg;
    logic bus_drive_dom_reg;
    logic bus_drive_en_reg;
    logic split_en_reg;
    logic wake_reg;

    ctmfl_fifo_if #(.W(FIFO_WIDTH)) fifo_bus ();

    assign tx_eff = tx_bit_driven ? tx_bit_in : 1'h1;
    assign standby_eff = standby_select_driven ? standby_select_in : 1'h1;
    assign resolved_dom = bus_dom_in || (bus_drive_dom_reg && bus_drive_en_reg);
    assign supplies_ok = vdd_ok && vio_ok;
    assign drv_ok = powered_reg && supplies_ok && !over_temp;
    assign filt_active = (mode_reg == MODE_STANDBY) && lp_en_reg && supplies_ok;
    assign wake_now = filt_active && filt_dom_reg && !bus_lock_reg;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_reg <= MODE_STANDBY;
        end else if (ce) begin
            mode_reg <= standby_eff ? MODE_STANDBY : MODE_NORMAL;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            powered_reg <= FLAG_RST;
        end else if (ce && supplies_ok) begin
            powered_reg <= 1'h1;
        end
    end

    // The low-power receiver is left running once armed, but filt_active still needs both
    // supplies, so a dip on either one hides bus activity; it drops only in normal mode.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lp_en_reg <= FLAG_RST;
        end else if (ce) begin
            if (mode_reg == MODE_NORMAL) begin
                lp_en_reg <= 1'h0;
            end else if (supplies_ok) begin
                lp_en_reg <= 1'h1;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_cnt_reg <= '0;
            tx_lock_reg <= FLAG_RST;
        end else if (ce) begin
            if (tx_eff || mode_reg != MODE_NORMAL) begin
                tx_cnt_reg <= '0;
                tx_lock_reg <= 1'h0;
            end else if (!tx_lock_reg) begin
                if (tx_cnt_reg == TMO_LAST) begin
                    tx_lock_reg <= 1'h1;
                end else begin
                    tx_cnt_reg <= TMO_W'(tx_cnt_reg + 1'h1);
                end
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bus_cnt_reg <= '0;
            bus_lock_reg <= FLAG_RST;
        end else if (ce) begin
            if (!resolved_dom || mode_reg != MODE_STANDBY) begin
                bus_cnt_reg <= '0;
                bus_lock_reg <= 1'h0;
            end else if (!bus_lock_reg) begin
                if (bus_cnt_reg == TMO_LAST) begin
                    bus_lock_reg <= 1'h1;
                end else begin
                    bus_cnt_reg <= TMO_W'(bus_cnt_reg + 1'h1);
                end
            end
        end
    end

    // delay line.
    // The filter drains only when full, so its delay is the FIFO depth in samples, about twice that in cycles;
    // pushes stall while full, which halves the sample rate but keeps the
    // buffer honest.
    assign fifo_bus.push_valid = filt_active;
    assign fifo_bus.push_data = resolved_dom;
    assign fifo_bus.pop_ready = filt_active && fifo_bus.full;
    // Stale dominant samples are dropped while the bus timeout holds, so the
    // return to recessive cannot replay an old wake-up from the delay line.
    assign fifo_bus.flush = !filt_active || bus_lock_reg;

    ctmfl_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .fifo(fifo_bus)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            filt_dom_reg <= FLAG_RST;
        end else if (ce) begin
            if (!filt_active || bus_lock_reg) begin
                filt_dom_reg <= 1'h0;
            end else if (fifo_bus.pop_valid && fifo_bus.pop_ready) begin
                filt_dom_reg <= fifo_bus.pop_data[0];
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_bit_reg <= RX_RST;
        end else if (ce) begin
            if (mode_reg == MODE_NORMAL) begin
                rx_bit_reg <= !vdd_ok || !resolved_dom;
            end else begin
                rx_bit_reg <= !wake_now;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wake_reg <= FLAG_RST;
        end else if (ce) begin
            wake_reg <= wake_now;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bus_drive_dom_reg <= DRV_RST;
        end else if (ce) begin
            bus_drive_dom_reg <= (mode_reg == MODE_NORMAL) && !tx_eff && !tx_lock_reg;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bus_drive_en_reg <= DRV_RST;
        end else if (ce) begin
            bus_drive_en_reg <= drv_ok && (mode_reg == MODE_NORMAL);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            split_en_reg <= DRV_RST;
        end else if (ce) begin
            split_en_reg <= (mode_reg == MODE_NORMAL) && vdd_ok;
        end
    end

    assign rx_bit = rx_bit_reg;
    assign bus_drive_dom = bus_drive_dom_reg;
    assign bus_drive_en = bus_drive_en_reg;
    assign split_en = split_en_reg;
    assign standby_active = (mode_reg == MODE_STANDBY);
    assign tx_timeout = tx_lock_reg;
    assign bus_timeout = bus_lock_reg;
    assign wake_pending = wake_reg;

    property p_tx_drive;
        @(posedge clock) disable iff (rst)
        ce && mode_reg == MODE_NORMAL && !tx_eff && !tx_lock_reg |=> bus_drive_dom_reg;
    endproperty
    a_tx_drive: assert property (p_tx_drive)
        else $error("Transmit low did not drive dominant.");

    property p_tx_lock;
        @(posedge clock) disable iff (rst)
        ce && tx_lock_reg |=> !bus_drive_dom_reg;
    endproperty
    a_tx_lock: assert property (p_tx_lock)
        else $error("Driver active after transmit timeout.");

    property p_tx_count;
        @(posedge clock) disable iff (rst)
        ce && !tx_lock_reg && tx_cnt_reg == TMO_LAST && !tx_eff
            && mode_reg == MODE_NORMAL |=> tx_lock_reg;
    endproperty
    a_tx_count: assert property (p_tx_count)
        else $error("Transmit timeout missed terminal count.");

    property p_thermal;
        @(posedge clock) disable iff (rst)
        ce && (over_temp || !vdd_ok) |=> !bus_drive_en_reg;
    endproperty
    a_thermal: assert property (p_thermal)
        else $error("Drivers enabled during a fault.");

    property p_uv_rx;
        @(posedge clock) disable iff (rst)
        ce && mode_reg == MODE_NORMAL && !vdd_ok |=> rx_bit_reg;
    endproperty
    a_uv_rx: assert property (p_uv_rx)
        else $error("Receive not recessive in undervoltage.");

    property p_rx_follow;
        @(posedge clock) disable iff (rst)
        ce && mode_reg == MODE_NORMAL && vdd_ok && resolved_dom |=> !rx_bit_reg;
    endproperty
    a_rx_follow: assert property (p_rx_follow)
        else $error("Receive did not follow dominant bus.");

    property p_bus_lock;
        @(posedge clock) disable iff (rst)
        ce && bus_lock_reg && mode_reg == MODE_STANDBY |=> rx_bit_reg;
    endproperty
    a_bus_lock: assert property (p_bus_lock)
        else $error("Receive not held high after bus timeout.");

    property p_wake;
        @(posedge clock) disable iff (rst)
        ce && wake_now && mode_reg == MODE_STANDBY |=> !rx_bit_reg && wake_reg;
    endproperty
    a_wake: assert property (p_wake)
        else $error("Wake-up not shown on receive.");

    property p_standby_off;
        @(posedge clock) disable iff (rst)
        ce && mode_reg == MODE_STANDBY |=> !bus_drive_dom_reg && !split_en_reg;
    endproperty
    a_standby_off: assert property (p_standby_off)
        else $error("Transmitter or reference on in standby.");

    property p_powerup;
        @(posedge clock) disable iff (rst)
        ce && !powered_reg |=> !bus_drive_en_reg;
    endproperty
    a_powerup: assert property (p_powerup)
        else $error("Drivers enabled before power-up.");

    property p_rearm;
        @(posedge clock) disable iff (rst)
        ce && bus_lock_reg |=> !filt_dom_reg;
    endproperty
    a_rearm: assert property (p_rearm)
        else $error("Filter kept a stale dominant sample.");

    property p_wake_supply;
        @(posedge clock) disable iff (rst)
        ce && !supplies_ok |=> !wake_reg;
    endproperty
    a_wake_supply: assert property (p_wake_supply)
        else $error("Wake-up shown without both supplies.");

    property p_split_off;
        @(posedge clock) disable iff (rst)
        ce && !vdd_ok |=> !split_en_reg;
    endproperty
    a_split_off: assert property (p_split_off)
        else $error("Reference output active without main supply.");

    property p_lp_hold;
        @(posedge clock) disable iff (rst)
        ce && lp_en_reg && mode_reg == MODE_STANDBY |=> lp_en_reg;
    endproperty
    a_lp_hold: assert property (p_lp_hold)
        else $error("Low-power receiver dropped in standby.");

    property p_mode;
        @(posedge clock) disable iff (rst)
        ce && standby_eff |=> mode_reg == MODE_STANDBY;
    endproperty
    a_mode: assert property (p_mode)
        else $error("Standby select high did not give standby.");
endmodule : ctmfl_top

// file: ctmfl_ctrl_model.sv
// Behavioural CAN controller model that drives the transceiver's logic pins.
// Assumes the bench steers it through want and float controls on the same clock.
`timescale 1ns/100ps
module ctmfl_ctrl_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Bench controls
    input wire logic tx_want,
    input wire logic standby_select_want,
    input wire logic float_tx,
    input wire logic float_standby_select,
    input wire logic wake_ack_en,
    // Transceiver side
    input wire logic rx_bit,
    input wire logic standby_active,
    output logic tx_bit_in,
    output logic tx_bit_driven,
    output logic standby_select_in,
    output logic standby_select_driven,
    output logic [7:0] wake_cnt
);
    logic rx_prev_reg;
    logic ack_reg;

    // floating pins
    // A released pin shows the level opposite its pull-up, so a missed pull-up is seen.
    assign tx_bit_driven = !float_tx;
    assign tx_bit_in = float_tx ? 1'h0 : tx_want;
    assign standby_select_driven = !float_standby_select;
    assign standby_select_in = float_standby_select ? 1'h0 : (standby_select_want && !ack_reg);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_prev_reg <= 1'h1;
            ack_reg <= 1'h0;
            wake_cnt <= 8'h00;
        end else begin
            rx_prev_reg <= rx_bit;
            if (standby_active && wake_ack_en && rx_prev_reg && !rx_bit) begin
                ack_reg <= 1'h1;
                wake_cnt <= wake_cnt + 8'h01;
            end else if (!standby_select_want) begin
                ack_reg <= 1'h0;
            end
        end
    end
endmodule : ctmfl_ctrl_model

// file: ctmfl_bench.sv
// Self-checking bench for the transceiver mode and fault logic.
// Assumes a short dominant timeout so that the filter delay still fits under it.
`timescale 1ns/100ps
module ctmfl_bench;
    localparam int unsigned TMO = 100;
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic ce = 1'h1;
    logic vdd_ok = 1'h0;
    logic vio_ok = 1'h0;
    logic over_temp = 1'h0;
    logic bus_dom_in = 1'h0;
    logic tx_want = 1'h1;
    logic standby_select_want = 1'h0;
    logic float_tx = 1'h0;
    logic float_standby_select = 1'h0;
    logic wake_ack_en = 1'h0;
    logic tx_bit_in, tx_bit_driven, standby_select_in, standby_select_driven;
    logic rx_bit, bus_drive_dom, bus_drive_en, split_en;
    logic standby_active, tx_timeout, bus_timeout, wake_pending;
    logic [7:0] wake_cnt;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    logic t, b;

    ctmfl_top #(.DOM_TIMEOUT_CYC(TMO)) uut (.clock(clock), .rst(rst), .ce(ce),
        .tx_bit_in(tx_bit_in), .tx_bit_driven(tx_bit_driven),
        .standby_select_in(standby_select_in), .standby_select_driven(standby_select_driven),
        .rx_bit(rx_bit), .bus_dom_in(bus_dom_in), .bus_drive_dom(bus_drive_dom),
        .bus_drive_en(bus_drive_en), .split_en(split_en), .vdd_ok(vdd_ok), .vio_ok(vio_ok),
        .over_temp(over_temp), .standby_active(standby_active), .tx_timeout(tx_timeout),
        .bus_timeout(bus_timeout), .wake_pending(wake_pending));

    ctmfl_ctrl_model ctrl (.clock(clock), .rst(rst), .tx_want(tx_want), .standby_select_want(standby_select_want),
        .float_tx(float_tx), .float_standby_select(float_standby_select), .wake_ack_en(wake_ack_en),
        .rx_bit(rx_bit), .standby_active(standby_active), .tx_bit_in(tx_bit_in),
        .tx_bit_driven(tx_bit_driven), .standby_select_in(standby_select_in),
        .standby_select_driven(standby_select_driven), .wake_cnt(wake_cnt));

    always #5 clock = !clock;

    function automatic logic exp_dom(input logic tx);
        return !tx;
    endfunction : exp_dom

    // Our own dominant drive counts into the resolved bus level.
    function automatic logic exp_rx(input logic tx, input logic bus);
        return !(bus || !tx);
    endfunction : exp_rx

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    task automatic wrap_up();
        $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    // The whole run needs under a thousand cycles.
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            error_cnt++;
            wrap_up();
        end
    end

    initial begin
        void'($urandom(32'h1f49));
        tick(5);
        check({rx_bit, bus_drive_en, split_en, standby_active}, 8'h09);
        @(posedge clock) rst <= 1'h0;
        tick(10);
        check(bus_drive_en, 1'h0);
        @(posedge clock) {vdd_ok, vio_ok} <= 2'h3;
        tick(6);
        check({standby_active, bus_drive_en, split_en}, 8'h03);
        for (int i = 0; i < 40; i++) begin
            t = (i % 4 == 3) ? 1'h1 : 1'($urandom_range(0, 1));
            b = 1'($urandom_range(0, 1));
            @(posedge clock);
            tx_want <= t;
            bus_dom_in <= b;
            tick(3);
            check(bus_drive_dom, exp_dom(t));
            check(rx_bit, exp_rx(t, b));
        end
        // Each fault alone must drop the drivers; only a main supply loss forces rx high.
        for (int f = 0; f < 3; f++) begin
            @(posedge clock);
            tx_want <= 1'h1;
            bus_dom_in <= 1'h1;
            over_temp <= (f == 0);
            vio_ok <= (f != 1);
            vdd_ok <= (f != 2);
            tick(4);
            check(bus_drive_en, 1'h0);
            check(rx_bit, (f == 2) ? 1'h1 : 1'h0);
            check(split_en, (f == 2) ? 1'h0 : 1'h1);
            @(posedge clock) {over_temp, vio_ok, vdd_ok} <= 3'h3;
            tick(4);
            check(bus_drive_en, 1'h1);
        end
        @(posedge clock) {bus_dom_in, tx_want} <= 2'h0;
        tick(TMO / 2);
        check({tx_timeout, bus_drive_dom}, 8'h01);
        tick(TMO - 20);
        check({tx_timeout, bus_drive_dom}, 8'h02);
        @(posedge clock) tx_want <= 1'h1;
        tick(3);
        check(tx_timeout, 1'h0);
        @(posedge clock) tx_want <= 1'h0;
        tick(TMO / 2);
        check(bus_drive_dom, 1'h1);
        @(posedge clock) {tx_want, float_tx} <= 2'h3;
        tick(3);
        check(bus_drive_dom, 1'h0);
        @(posedge clock) {float_tx, standby_select_want} <= 2'h1;
        tick(4);
        check({standby_active, bus_drive_en, split_en}, 8'h04);
        tick(50);
        @(posedge clock) bus_dom_in <= 1'h1;
        tick(5);
        check(rx_bit, 1'h1);
        repeat (80) if (rx_bit !== 1'h0) tick(1);
        check({rx_bit, wake_pending}, 8'h01);
        tick(TMO + 30);
        check({rx_bit, bus_timeout}, 8'h03);
        @(posedge clock) bus_dom_in <= 1'h0;
        tick(20);
        check(rx_bit, 1'h1);
        tick(40);
        check({rx_bit, bus_timeout}, 8'h02);
        @(posedge clock) {vio_ok, bus_dom_in} <= 2'h1;
        tick(60);
        check(rx_bit, 1'h1);
        @(posedge clock) {vio_ok, bus_dom_in, wake_ack_en} <= 3'h5;
        tick(60);
        @(posedge clock) {bus_dom_in, wake_ack_en} <= 2'h3;
        repeat (80) if (rx_bit !== 1'h0) tick(1);
        tick(6);
        check({wake_cnt, standby_active}, 9'h002);
        @(posedge clock) {bus_dom_in, float_standby_select} <= 2'h1;
        tick(4);
        check(standby_active, 1'h1);
        wrap_up();
    end
endmodule : ctmfl_bench
